//--- hw/automatic_dma_mode_ctl.sv
// Purpose: automatic dma event mask, status mirror, packet count, error retry
// Assumes: axi4-lite slave, endpoint status and packet events from the sie
// Notes: see functional notes below

`timescale 1ns/1ps

module automatic_dma_mode_ctl
  import automatic_dma_mode_ctl_pkg::*;
#(
  parameter int NUM_EP = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_EP*8-1:0] ep_status,
  input wire logic tx_dir,
  input wire pkt_evt_t pkt_evt,
  input wire logic sw_halt,
  output logic automatic_dma_mode_active,
  output logic [2:0] dma_source_select,
  output logic alt_dma_flag,
  output err_act_t err_act
);

  // ==========================================================
  // state
  logic [3:0] mask_r;
  logic [7:0] count_r;
  logic aeh_r;
  logic [6:0] preset_r;
  logic [6:0] errcnt_r;
  logic [3:0] event_r;
  logic [7:0] ctl_r;
  logic automatic_dma_mode_r;
  logic alt_r;
  logic [7:0] mirror_r;
  err_act_t act_r;

  // ==========================================================
  // axi write channel
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wr_lane0;

  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_lane0 = wr_fire && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && !aw_have_r) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && !w_have_r) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  logic wr_mapped;
  always_comb begin
    unique case (awaddr_r)
      OFF_EVENT_MASK, OFF_STATUS_MIRROR, OFF_PACKET_COUNT,
      OFF_ERROR_CONTROL, OFF_DMA_CONTROL, OFF_DMA_EVENT,
      OFF_ALT_EVENT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  logic wr_mask, wr_count, wr_err, wr_ctl, wr_event, wr_alt;
  assign wr_mask = wr_lane0 && awaddr_r == OFF_EVENT_MASK;
  assign wr_count = wr_lane0 && awaddr_r == OFF_PACKET_COUNT;
  assign wr_err = wr_lane0 && awaddr_r == OFF_ERROR_CONTROL;
  assign wr_ctl = wr_lane0 && awaddr_r == OFF_DMA_CONTROL;
  assign wr_event = wr_lane0 && awaddr_r == OFF_DMA_EVENT;
  assign wr_alt = wr_lane0 && awaddr_r == OFF_ALT_EVENT;

  // ==========================================================
  // packet outcome decode
  logic op_good, op_err, evt_any;
  // rx: good reception, then moved; tx: moved, then sent and acked
  assign op_good = automatic_dma_mode_r && pkt_evt.done && pkt_evt.ok
                   && pkt_evt.moved;
  assign op_err = automatic_dma_mode_r && pkt_evt.done && !pkt_evt.ok;

  logic [3:0] evt_set;
  logic err_exhausted;
  assign err_exhausted = !aeh_r || errcnt_r == 7'h00;
  always_comb begin
    evt_set = 4'h0;
    evt_set[EV_SHORT] = op_good && !tx_dir && pkt_evt.short_pkt;
    evt_set[EV_COUNT] = op_good && count_r == 8'h00;
    evt_set[EV_ERROR] = op_err && err_exhausted;
    evt_set[EV_HALT] = automatic_dma_mode_r && sw_halt;
  end

  // ==========================================================
  // dma event register: set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= 4'h0;
    end else begin
      event_r <= (event_r & ~(wr_event ? wdata_r[3:0] : 4'h0)) | evt_set;
    end
  end
  assign evt_any = |event_r;

  // ==========================================================
  // control: source select, iso mode, automatic mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= 8'h00;
    end else if (wr_ctl) begin
      ctl_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      automatic_dma_mode_r <= 1'b0;
    end else if (evt_any || |evt_set) begin
      automatic_dma_mode_r <= 1'b0;
    end else if (wr_ctl) begin
      automatic_dma_mode_r <= wdata_r[CTL_AUTOMATIC_DMA_MODE];
    end
  end

  // ==========================================================
  // event mask and alternate event flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= wdata_r[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_r <= 1'b0;
    end else if (|(evt_set & mask_r)) begin
      alt_r <= 1'b1;
    end else if (wr_alt && wdata_r[ALT_DMA_BIT]) begin
      alt_r <= 1'b0;
    end
  end

  // ==========================================================
  // status mirror, a plain copy so the source is never touched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mirror_r <= 8'h00;
    end else begin
      mirror_r <= ep_status[ctl_r[CTL_SRC_LO +: 3]*8 +: 8];
    end
  end

  // ==========================================================
  // packet countdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RST;
    end else if (wr_count) begin
      count_r <= wdata_r[7:0];
    end else if (op_good && count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end

  // ==========================================================
  // error preset and live counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aeh_r <= 1'b0;
      preset_r <= ERRCNT_RST;
    end else if (wr_err && !automatic_dma_mode_r) begin
      aeh_r <= wdata_r[AEH_BIT];
      preset_r <= wdata_r[6:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      errcnt_r <= ERRCNT_RST;
    end else if (!automatic_dma_mode_r || op_good) begin
      errcnt_r <= preset_r;
    end else if (op_err && aeh_r && errcnt_r != 7'h00) begin
      errcnt_r <= errcnt_r - 7'h01;
    end
  end

  // ==========================================================
  // automatic error actions, one-cycle pulses
  logic retry;
  assign retry = op_err && aeh_r && errcnt_r != 7'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= '0;
    end else begin
      act_r.reload_tx <= retry && tx_dir && !ctl_r[CTL_ISO];
      act_r.flush_rx <= retry && !tx_dir;
      act_r.drop_rx <= retry && !tx_dir && ctl_r[CTL_ISO];
    end
  end

  // ==========================================================
  // axi read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_byte;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_EVENT_MASK: rd_byte = {4'h0, mask_r};
      OFF_STATUS_MIRROR: rd_byte = mirror_r;
      OFF_PACKET_COUNT: rd_byte = count_r;
      OFF_ERROR_CONTROL:
        rd_byte = {aeh_r, automatic_dma_mode_r ? errcnt_r : preset_r};
      OFF_DMA_CONTROL: rd_byte = {ctl_r[7:1], automatic_dma_mode_r};
      OFF_DMA_EVENT: rd_byte = {4'h0, event_r};
      OFF_ALT_EVENT: rd_byte = {7'h00, alt_r};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ==========================================================
  // outputs
  assign automatic_dma_mode_active = automatic_dma_mode_r;
  assign dma_source_select = ctl_r[CTL_SRC_LO +: 3];
  assign alt_dma_flag = alt_r;
  assign err_act = act_r;

endmodule : automatic_dma_mode_ctl

//--- hw/automatic_dma_mode_ctl_pkg.sv
// Purpose: shared constants and types for the automatic dma control block
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes: register offsets are byte addresses

package automatic_dma_mode_ctl_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_EVENT_MASK = 8'h00;
  localparam logic [7:0] OFF_STATUS_MIRROR = 8'h04;
  localparam logic [7:0] OFF_PACKET_COUNT = 8'h08;
  localparam logic [7:0] OFF_ERROR_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_DMA_CONTROL = 8'h10;
  localparam logic [7:0] OFF_DMA_EVENT = 8'h14;
  localparam logic [7:0] OFF_ALT_EVENT = 8'h18;

  // ==========================================================
  // field positions
  localparam int EV_SHORT = 3;
  localparam int EV_COUNT = 2;
  localparam int EV_ERROR = 1;
  localparam int EV_HALT = 0;
  localparam int AEH_BIT = 7;
  localparam int CTL_AUTOMATIC_DMA_MODE = 0;
  localparam int CTL_ISO = 1;
  localparam int CTL_SRC_LO = 4;
  localparam int ALT_DMA_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [6:0] ERRCNT_RST = 7'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status of one endpoint direction, as seen by this block
  typedef struct packed {
    logic done;      // packet finished on the bus
    logic ok;        // finished without error (ack seen / rx good)
    logic moved;     // dma moved the packet to/from memory
    logic short_pkt; // receive packet shorter than fifo
  } pkt_evt_t;

  typedef struct packed {
    logic reload_tx; // reload fifo and reschedule
    logic flush_rx;  // flush receive fifo
    logic drop_rx;   // iso: discard without dma
  } err_act_t;

endpackage : automatic_dma_mode_ctl_pkg

//--- tb/automatic_dma_mode_ctl_asserts.sv
// Purpose: port assertions for the auto dma control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every automatic_dma_mode_ctl instance
`timescale 1ns/1ps
module automatic_dma_mode_ctl_asserts
  import automatic_dma_mode_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_dir,
  input wire pkt_evt_t pkt_evt,
  input wire logic sw_halt,
  input wire logic automatic_dma_mode_active,
  input wire logic alt_dma_flag,
  input wire err_act_t err_act
);
  // ==========================================================
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken in read");
  a_act_cause: assert property (err_act != 3'h0 |->
    $past(pkt_evt.done && !pkt_evt.ok && automatic_dma_mode_active)) else $error("no cause");
  a_tx_reload: assert property (err_act.reload_tx |->
    $past(tx_dir) && !err_act.flush_rx) else $error("bad reload");
  a_rx_flush: assert property (err_act.flush_rx |-> !$past(tx_dir))
    else $error("bad flush");
  a_drop_flush: assert property (err_act.drop_rx |-> err_act.flush_rx)
    else $error("drop without flush");
  a_halt_ends: assert property (automatic_dma_mode_active && sw_halt |->
    ##[1:2] !automatic_dma_mode_active) else $error("mode not ended");
  a_flag_cause: assert property ($rose(alt_dma_flag) |->
    $past(pkt_evt.done | sw_halt) || $past(pkt_evt.done | sw_halt, 2))
    else $error("flag without event");
endmodule : automatic_dma_mode_ctl_asserts

bind automatic_dma_mode_ctl automatic_dma_mode_ctl_asserts chk_u (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tx_dir, .pkt_evt, .sw_halt,
  .automatic_dma_mode_active, .alt_dma_flag, .err_act);

//--- tb/automatic_dma_mode_sie_model.sv
// Purpose: endpoint engine model facing the auto dma control block
// Assumes: packet completions arrive as one-cycle pulses
// Notes: status bytes all differ, so a wrong select shows
`timescale 1ns/1ps
module automatic_dma_mode_sie_model
  import automatic_dma_mode_ctl_pkg::*;
(
  input wire logic aclk,
  output logic [63:0] ep_status,
  output logic tx_dir,
  output pkt_evt_t pkt_evt,
  output logic sw_halt
);
  assign ep_status = 64'hA7A6A5A4A3A2A1A0;
  initial begin
    tx_dir = 1'b0;
    pkt_evt = '0;
    sw_halt = 1'b0;
  end
  // ==========================================================
  // stimulus tasks
  // moved only with the dma leg finished first
  task automatic pkt(input logic ok, input logic mv);
    @(posedge aclk);
    pkt_evt <= '{done: 1'b1, ok: ok, moved: mv, short_pkt: 1'b0};
    @(posedge aclk);
    pkt_evt <= '0;
  endtask : pkt
  task automatic halt();
    @(posedge aclk);
    sw_halt <= 1'b1;
    @(posedge aclk);
    sw_halt <= 1'b0;
  endtask : halt
  task automatic dir(input logic d);
    @(posedge aclk);
    tx_dir <= d;
  endtask : dir
endmodule : automatic_dma_mode_sie_model

//--- tb/test_auto_dma_count_error_control.sv
// Purpose: self-checking bench for the auto dma control block
// Assumes: axi4-lite master tasks, endpoint model drives packets
// Notes: register rows first, then mode and error sequences
`timescale 1ns/1ps
module test_auto_dma_count_error_control
  import automatic_dma_mode_ctl_pkg::*;
();
  typedef struct {logic [7:0] a, d, q; logic [1:0] r;} row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx_dir;
  logic awready, wready, bvalid, arready, rvalid, sw_halt, automatic_dma_mode_active;
  logic alt_dma_flag;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [1:0] bresp, rresp, wrsp, rrsp;
  logic [63:0] ep_status;
  logic [2:0] src_sel;
  pkt_evt_t pkt_evt;
  err_act_t err_act;
  int err_total, compares, n_rel, n_fl, n_dr;
  row_t rows[7] = '{
    '{OFF_EVENT_MASK, 8'h0F, 8'h0F, RESP_OKAY},
    '{OFF_PACKET_COUNT, 8'hFF, 8'hFF, RESP_OKAY},
    '{OFF_ERROR_CONTROL, 8'hFF, 8'hFF, RESP_OKAY},
    '{OFF_STATUS_MIRROR, 8'h3C, 8'hA0, RESP_OKAY},
    '{OFF_DMA_CONTROL, 8'h50, 8'h50, RESP_OKAY},
    '{OFF_STATUS_MIRROR, 8'h00, 8'hA5, RESP_OKAY},
    '{8'h1C, 8'h55, 8'h00, RESP_SLVERR}};

  automatic_dma_mode_ctl dut_u (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ep_status, .tx_dir, .pkt_evt, .sw_halt, .automatic_dma_mode_active,
    .dma_source_select(src_sel), .alt_dma_flag, .err_act);
  automatic_dma_mode_sie_model sie_u (.aclk, .ep_status, .tx_dir, .pkt_evt, .sw_halt);

  always #2 aclk = ~aclk;
  // error actions are one-cycle pulses, so count them as they pass
  always @(posedge aclk) begin
    if (err_act.reload_tx === 1'b1) n_rel <= n_rel + 1;
    if (err_act.flush_rx === 1'b1) n_fl <= n_fl + 1;
    if (err_act.drop_rx === 1'b1) n_dr <= n_dr + 1;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %0t: seen %h want %h", $time, s, e);
    end
  endtask : chk
  // each channel is released at the edge that takes it, answer at its edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic bv;
    bv = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !bv; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      bv = bvalid;
      wrsp = bresp;
    end
    bready <= 1'b0;
    if (!bv) begin
      err_total++;
      wrap_up();
    end
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] q);
    logic rv;
    rv = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !rv; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      rv = rvalid;
      rdat = rdata;
      rrsp = rresp;
    end
    rready <= 1'b0;
    chk(rdat, {24'h0, q});
    if (!rv) begin
      err_total++;
      wrap_up();
    end
  endtask : rdc
  task automatic clr();
    wr(OFF_DMA_EVENT, 8'h0F);
    wr(OFF_ALT_EVENT, 8'h01);
  endtask : clr

  // ==========================================================
  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a != OFF_STATUS_MIRROR) chk(wrsp, rows[i].r);
      rdc(rows[i].a, rows[i].q);
      chk(rrsp, rows[i].r);
    end
    chk(src_sel, 3'h5);
    wr(OFF_PACKET_COUNT, 8'h01);
    wr(OFF_ERROR_CONTROL, 8'h82);
    wr(OFF_EVENT_MASK, 8'h04);
    wr(OFF_DMA_CONTROL, 8'h01);
    chk(automatic_dma_mode_active, 1'b1);
    sie_u.pkt(1'b1, 1'b0);
    rdc(OFF_PACKET_COUNT, 8'h01);
    sie_u.pkt(1'b1, 1'b1);
    rdc(OFF_PACKET_COUNT, 8'h00);
    chk(alt_dma_flag, 1'b0);
    sie_u.pkt(1'b1, 1'b1);
    rdc(OFF_PACKET_COUNT, 8'h00);
    rdc(OFF_DMA_EVENT, 8'h04);
    chk(automatic_dma_mode_active, 1'b0);
    chk(alt_dma_flag, 1'b1);
    clr();
    wr(OFF_PACKET_COUNT, 8'hFF);
    wr(OFF_EVENT_MASK, 8'h02);
    wr(OFF_DMA_CONTROL, 8'h01);
    sie_u.pkt(1'b0, 1'b0);
    rdc(OFF_ERROR_CONTROL, 8'h81);
    wr(OFF_ERROR_CONTROL, 8'h05);
    rdc(OFF_ERROR_CONTROL, 8'h81);
    sie_u.pkt(1'b1, 1'b1);
    rdc(OFF_ERROR_CONTROL, 8'h82);
    repeat (3) sie_u.pkt(1'b0, 1'b0);
    rdc(OFF_DMA_EVENT, 8'h02);
    rdc(OFF_ERROR_CONTROL, 8'h82);
    chk(n_fl, 3);
    chk(alt_dma_flag, 1'b1);
    clr();
    sie_u.dir(1'b1);
    wr(OFF_DMA_CONTROL, 8'h01);
    sie_u.pkt(1'b0, 1'b0);
    // action pulse lands one edge later, its count one more
    repeat (2) @(negedge aclk);
    chk(n_rel, 1);
    sie_u.halt();
    rdc(OFF_DMA_EVENT, 8'h01);
    wr(OFF_DMA_CONTROL, 8'h01);
    chk(automatic_dma_mode_active, 1'b0);
    chk(alt_dma_flag, 1'b0);
    clr();
    sie_u.dir(1'b0);
    wr(OFF_DMA_CONTROL, 8'h03);
    sie_u.pkt(1'b0, 1'b0);
    repeat (2) @(negedge aclk);
    chk(n_dr, 1);
    sie_u.halt();
    clr();
    wr(OFF_ERROR_CONTROL, 8'h02);
    wr(OFF_DMA_CONTROL, 8'h01);
    sie_u.pkt(1'b0, 1'b0);
    rdc(OFF_DMA_EVENT, 8'h02);
    chk(n_fl + n_rel, 5);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_PACKET_COUNT, 8'h00);
    rdc(OFF_ERROR_CONTROL, 8'h00);
    chk(automatic_dma_mode_active, 1'b0);
    wrap_up();
  end
endmodule : test_auto_dma_count_error_control
